/* rtl/smi_exec_defs.vh */
// constants for the shift, move and indirect-load execution block
`ifndef SMI_EXEC_DEFS_VH
`define SMI_EXEC_DEFS_VH

// ==========================================================================
// register byte offsets
`define SMI_OFS_INSTR    12'h000
`define SMI_OFS_WREG     12'h004
`define SMI_OFS_STATUS   12'h008
`define SMI_OFS_PTR0     12'h00c
`define SMI_OFS_PTR1     12'h010

// ==========================================================================
// instruction word fields
`define SMI_OP_LO        0
`define SMI_OP_HI        1
`define SMI_DEST_BIT     2
`define SMI_PSEL_BIT     3
`define SMI_MODE_LO      4
`define SMI_MODE_HI      5
`define SMI_REL_BIT      6
`define SMI_FADDR_LO     8
`define SMI_FADDR_HI     14
`define SMI_OFFS_LO      16
`define SMI_OFFS_HI      21

// opcodes
`define SMI_OP_NONE      2'h0
`define SMI_OP_SHIFT     2'h1
`define SMI_OP_MOVE      2'h2
`define SMI_OP_ILOAD     2'h3

// pointer update modes
`define SMI_MODE_PREINC  2'h0
`define SMI_MODE_PREDEC  2'h1
`define SMI_MODE_POSTINC 2'h2
`define SMI_MODE_POSTDEC 2'h3

// ==========================================================================
// status fields
`define SMI_ST_CARRY     0
`define SMI_ST_ZERO      1
`define SMI_ST_BUSY      8

// ==========================================================================
// indirect data port addresses in the file space
`define SMI_IND0_ADDR    7'h00
`define SMI_IND1_ADDR    7'h01

// ==========================================================================
// reset values
`define SMI_RST_WREG     8'h00
`define SMI_RST_PTR      16'h0000
`define SMI_RST_FLAG     1'b0

`endif

/* rtl/smi_exec.v */
// execution datapath for right shift, file move and indirect load
`timescale 1ns/10ps
`default_nettype none
`include "smi_exec_defs.vh"

module smi_exec (
  input  wire        ref_clk,      // core clock
  input  wire        rst,          // synchronous reset, active high
  input  wire        psel,         // apb select
  input  wire        penable,      // apb access phase
  input  wire        pwrite,       // apb direction
  input  wire [11:0] paddr,        // apb byte address
  input  wire [31:0] pwdata,       // apb write data
  output reg  [31:0] prdata,       // apb read data
  output reg         pready,       // apb ready
  output reg         pslverr,      // apb error on unmapped address
  output reg  [15:0] fileAddr,     // file bus address
  output reg         fileRe,       // file bus read strobe
  output reg         fileWe,       // file bus write strobe
  output reg  [7:0]  fileWrData,   // file bus write data
  input  wire [7:0]  fileRdData,   // file bus read data, one cycle after fileRe
  output reg  [7:0]  wRegOut,      // working register
  output reg         carryOut,     // carry flag
  output reg         zeroOut       // zero flag
);

  // ========================================================================
  // state machine codes
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_READ = 2'h1;
  localparam [1:0] ST_CAPT = 2'h2;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [1:0]  op_q;
  reg         dest_q;
  reg  [7:0]  wReg_q;
  reg         carry_q;
  reg         zero_q;
  reg  [15:0] ptr0_q;
  reg  [15:0] ptr1_q;

  // ========================================================================
  // apb decode
  wire        apbAccess = psel & penable & pready;
  wire        apbWrite  = apbAccess & pwrite;
  wire        busy      = (state_q != ST_IDLE);
  wire        hitInstr  = (paddr == `SMI_OFS_INSTR);
  wire        hitWreg   = (paddr == `SMI_OFS_WREG);
  wire        hitStatus = (paddr == `SMI_OFS_STATUS);
  wire        hitPtr0   = (paddr == `SMI_OFS_PTR0);
  wire        hitPtr1   = (paddr == `SMI_OFS_PTR1);
  wire        hitAny    = hitInstr | hitWreg | hitStatus | hitPtr0 | hitPtr1;
  // writes are refused while an instruction runs so state stays coherent
  wire        swWrite   = apbWrite & ~busy;
  wire        start     = swWrite & hitInstr & (pwdata[`SMI_OP_HI:`SMI_OP_LO] != `SMI_OP_NONE);

  // ========================================================================
  // instruction fields
  wire [1:0]  newOp     = pwdata[`SMI_OP_HI:`SMI_OP_LO];
  wire        newPsel   = pwdata[`SMI_PSEL_BIT];
  wire [1:0]  newMode   = pwdata[`SMI_MODE_HI:`SMI_MODE_LO];
  wire        newRel    = pwdata[`SMI_REL_BIT];
  wire [6:0]  newFaddr  = pwdata[`SMI_FADDR_HI:`SMI_FADDR_LO];
  wire [5:0]  newOffs   = pwdata[`SMI_OFFS_HI:`SMI_OFFS_LO];
  wire [15:0] offsExt   = {{10{newOffs[5]}}, newOffs};

  // ========================================================================
  // pointer arithmetic, all 16-bit so overflow wraps
  wire [15:0] selPtr    = newPsel ? ptr1_q : ptr0_q;
  wire [15:0] ptrInc    = selPtr + 16'h0001;
  wire [15:0] ptrDec    = selPtr - 16'h0001;
  wire [15:0] relAddr   = selPtr + offsExt;

  reg  [15:0] iAddr;
  reg  [15:0] ptrNext;
  always @* begin
    iAddr   = selPtr;
    ptrNext = selPtr;
    if (newRel) begin
      iAddr   = relAddr;
      ptrNext = selPtr;
    end else begin
      case (newMode)
        `SMI_MODE_PREINC: begin
          iAddr   = ptrInc;
          ptrNext = ptrInc;
        end
        `SMI_MODE_PREDEC: begin
          iAddr   = ptrDec;
          ptrNext = ptrDec;
        end
        `SMI_MODE_POSTINC: begin
          iAddr   = selPtr;
          ptrNext = ptrInc;
        end
        default: begin
          iAddr   = selPtr;
          ptrNext = ptrDec;
        end
      endcase
    end
  end

  // direct addresses that name an indirect port go where the pointer points
  reg  [15:0] dAddr;
  always @* begin
    if (newFaddr == `SMI_IND0_ADDR) begin
      dAddr = ptr0_q;
    end else if (newFaddr == `SMI_IND1_ADDR) begin
      dAddr = ptr1_q;
    end else begin
      dAddr = {9'h000, newFaddr};
    end
  end

  // ========================================================================
  // result path
  wire [7:0]  shiftRes  = {1'b0, fileRdData[7:1]};
  wire [7:0]  result    = (op_q == `SMI_OP_SHIFT) ? shiftRes : fileRdData;
  wire        resZero   = (result == 8'h00);
  wire        toFile    = dest_q & (op_q != `SMI_OP_ILOAD);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_READ;
        end
      end
      ST_READ: begin
        state_d = ST_CAPT;
      end
      ST_CAPT: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ========================================================================
  // sequencer and datapath registers
  always @(posedge ref_clk) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      op_q       <= `SMI_OP_NONE;
      dest_q     <= 1'b0;
      wReg_q     <= `SMI_RST_WREG;
      carry_q    <= `SMI_RST_FLAG;
      zero_q     <= `SMI_RST_FLAG;
      ptr0_q     <= `SMI_RST_PTR;
      ptr1_q     <= `SMI_RST_PTR;
      fileAddr   <= 16'h0000;
      fileRe     <= 1'b0;
      fileWe     <= 1'b0;
      fileWrData <= 8'h00;
    end else begin
      state_q <= state_d;
      fileRe  <= 1'b0;
      fileWe  <= 1'b0;
      if (start) begin
        op_q     <= newOp;
        dest_q   <= pwdata[`SMI_DEST_BIT];
        fileRe   <= 1'b1;
        if (newOp == `SMI_OP_ILOAD) begin
          fileAddr <= iAddr;
          if (newPsel) begin
            ptr1_q <= ptrNext;
          end else begin
            ptr0_q <= ptrNext;
          end
        end else begin
          fileAddr <= dAddr;
        end
      end else if (swWrite) begin
        if (hitWreg) begin
          wReg_q <= pwdata[7:0];
        end
        if (hitStatus) begin
          carry_q <= pwdata[`SMI_ST_CARRY];
          zero_q  <= pwdata[`SMI_ST_ZERO];
        end
        if (hitPtr0) begin
          ptr0_q <= pwdata[15:0];
        end
        if (hitPtr1) begin
          ptr1_q <= pwdata[15:0];
        end
      end
      if (state_q == ST_CAPT) begin
        zero_q <= resZero;
        if (op_q == `SMI_OP_SHIFT) begin
          carry_q <= fileRdData[0];
        end
        if (toFile) begin
          fileWe     <= 1'b1;
          fileWrData <= result;
        end else begin
          wReg_q <= result;
        end
      end
    end
  end

  // ========================================================================
  // apb slave: one wait state, ready and data both registered
  reg [31:0] rdMux;
  always @* begin
    rdMux = 32'h00000000;
    if (hitWreg) begin
      rdMux = {24'h000000, wReg_q};
    end else if (hitStatus) begin
      rdMux = {23'h000000, busy, 6'h00, zero_q, carry_q};
    end else if (hitPtr0) begin
      rdMux = {16'h0000, ptr0_q};
    end else if (hitPtr1) begin
      rdMux = {16'h0000, ptr1_q};
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      pready   <= 1'b0;
      prdata   <= 32'h00000000;
      pslverr  <= 1'b0;
      wRegOut  <= `SMI_RST_WREG;
      carryOut <= `SMI_RST_FLAG;
      zeroOut  <= `SMI_RST_FLAG;
    end else begin
      pready   <= psel & penable & ~pready;
      prdata   <= (psel & penable & ~pready & ~pwrite) ? rdMux : 32'h00000000;
      pslverr  <= psel & penable & ~pready & ~hitAny;
      wRegOut  <= wReg_q;
      carryOut <= carry_q;
      zeroOut  <= zero_q;
    end
  end

endmodule
`default_nettype wire

/* verification/smi_exec_chk.sv */
// port-level assertions for the shift, move and indirect-load block
`timescale 1ns/10ps
`default_nettype none
module smi_exec_chk (
  input wire logic        ref_clk,    // clock
  input wire logic        rst,        // sync reset
  input wire logic        psel,       // apb select
  input wire logic        penable,    // apb enable
  input wire logic        pwrite,     // apb direction
  input wire logic [11:0] paddr,      // apb address
  input wire logic [31:0] pwdata,     // apb write data
  input wire logic [31:0] prdata,     // apb read data
  input wire logic        pready,     // apb ready
  input wire logic        pslverr,    // apb error
  input wire logic [15:0] fileAddr,   // file address
  input wire logic        fileRe,     // file read
  input wire logic        fileWe,     // file write
  input wire logic [7:0]  fileWrData, // file write data
  input wire logic [7:0]  fileRdData, // file read data
  input wire logic [7:0]  wRegOut,    // working register
  input wire logic        carryOut,   // carry
  input wire logic        zeroOut     // zero
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ======
  // bus and sequencing
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_take;
    psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[1:0] != 2'h0;
  endsequence
  property p_rdy; s_wait |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_err;
    pready && paddr > 12'h010 |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_go; s_take |=> fileRe ##1 !fileRe; endproperty
  a_go: assert property (p_go) else $error("instruction not started");
  property p_we; fileWe |-> $past(fileRe, 2) && $stable(fileAddr); endproperty
  a_we: assert property (p_we) else $error("write back misplaced");
  // ======
  // results
  // flags and W reach the ports one cycle after the write-back strobe
  property p_res;
    fileWe |=> $past(fileWrData) == $past(fileRdData, 2) ||
      ($past(fileWrData) == {1'b0, $past(fileRdData[7:1], 2)} &&
       carryOut == $past(fileRdData[0], 2));
  endproperty
  a_res: assert property (p_res) else $error("bad write back");
  property p_zf; fileWe |=> zeroOut == ($past(fileWrData) == 8'h00); endproperty
  a_zf: assert property (p_zf) else $error("zero flag wrong");
  property p_wz;
    $past(fileRe, 3) && !$past(fileWe) |-> zeroOut == (wRegOut == 8'h00);
  endproperty
  a_wz: assert property (p_wz) else $error("zero flag on W wrong");
endmodule
bind smi_exec smi_exec_chk i_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fileAddr(fileAddr), .fileRe(fileRe),
  .fileWe(fileWe), .fileWrData(fileWrData), .fileRdData(fileRdData),
  .wRegOut(wRegOut), .carryOut(carryOut), .zeroOut(zeroOut));
`default_nettype wire

/* verification/tb_smi_exec.sv */
// self-checking bench for the shift, move and indirect-load block
`timescale 1ns/10ps
`default_nettype none
`include "smi_exec_defs.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t got %h exp %h", $time, (a), (b)); end end
module tb_smi_exec;
  logic        ref_clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, rs = 32'h85da;
  logic        pready, pslverr, fileRe, fileWe, carryOut, zeroOut, e, c, z, n, d, rel;
  logic [15:0] fileAddr, a;
  logic [15:0] p [0:1];
  logic [7:0]  fileWrData, fileRdData = 8'h00, wRegOut, w, dt, r;
  logic [7:0]  mem [0:65535];
  logic [6:0]  f;
  logic [5:0]  off;
  logic [1:0]  op, md;
  int          mismatches = 0, total_checks = 0, i;
  smi_exec i_smi_exec (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fileAddr(fileAddr), .fileRe(fileRe), .fileWe(fileWe),
    .fileWrData(fileWrData), .fileRdData(fileRdData), .wRegOut(wRegOut),
    .carryOut(carryOut), .zeroOut(zeroOut));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // file space: off-cycle data is inverted each cycle so stale bytes look valid only every other cycle
  always @(posedge ref_clk) begin
    fileRdData <= fileRe ? mem[fileAddr] : ~fileRdData;
    if (fileWe) mem[fileAddr] <= fileWrData;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] dv);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= ad; pwdata <= dv;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees ready
    do begin @(posedge ref_clk); end while (pready !== 1'b1);
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge ref_clk);
    mismatches++;
    summarize;
  end
  // ======
  // main sequence
  initial begin
    for (i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8];
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    apb(0, `SMI_OFS_PTR1, 0); `CHK(q, 32'h0)
    apb(0, 12'h014, 0); `CHK({q, e}, 33'h1)
    for (i = 0; i < 60; i++) begin
      rs = lfsr(rs);
      op = 2'(i % 3 + 1); f = (i < 12) ? 7'(i % 2) : rs[14:8]; off = rs[27:22];
      n = rs[3]; md = rs[5:4]; rel = rs[6]; d = rs[2];
      p[0] = (i < 24) ? {16{rs[16]}} : rs[31:16]; p[1] = ~p[0];
      apb(1, `SMI_OFS_PTR0, {16'h0, p[0]});
      apb(1, `SMI_OFS_PTR1, {16'h0, p[1]});
      apb(1, `SMI_OFS_WREG, {24'h0, rs[7:0]}); w = rs[7:0];
      apb(1, `SMI_OFS_STATUS, {30'h0, rs[9:8]}); {z, c} = rs[9:8];
      if (op != `SMI_OP_ILOAD) a = (f > 1) ? {9'h0, f} : p[f[0]];
      else if (rel) a = p[n] + {{10{off[5]}}, off};
      else begin
        if (!md[1]) p[n] = md[0] ? p[n] - 16'h1 : p[n] + 16'h1;
        a = p[n];
        if (md[1]) p[n] = md[0] ? p[n] - 16'h1 : p[n] + 16'h1;
      end
      dt = mem[a];
      r = (op == `SMI_OP_SHIFT) ? {1'b0, dt[7:1]} : dt;
      if (op == `SMI_OP_SHIFT) c = dt[0];
      z = (r == 8'h00);
      if (d && op != `SMI_OP_ILOAD) dt = r;
      else w = r;
      apb(1, `SMI_OFS_INSTR, {10'h0, off, 1'b0, f, 1'b0, rel, md, n, d, op});
      apb(0, `SMI_OFS_STATUS, 0); `CHK(q, {30'h0, z, c})
      apb(0, `SMI_OFS_WREG, 0); `CHK({q, e}, {24'h0, w, 1'b0})
      apb(0, n ? `SMI_OFS_PTR1 : `SMI_OFS_PTR0, 0); `CHK(q, {16'h0, p[n]})
      `CHK(mem[a], dt)
      `CHK({wRegOut, zeroOut, carryOut}, {w, z, c})
    end
    summarize;
  end
endmodule
`default_nettype wire
